//--- mtx_pkg.sv
// Constants, field layouts and types for the multimode timer channel.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package mtx_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_START  = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;
  localparam logic [7:0] ADDR_RELOAD = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Start register bits
  localparam int START_BIT   = 0;
  localparam int ONESHOT_BIT = 1;

  // Status register bits
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_PIN    = 1;
  localparam int STAT_UFLOW  = 2;

  // Reset values
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'hffff;
  localparam logic [15:0] RELOAD_RST = 16'hffff;

  // Prescaler terminal counts
  localparam logic [2:0] PRE_DIV8_LAST  = 3'h7;
  localparam logic [4:0] PRE_DIV32_LAST = 5'h1f;
  localparam logic [4:0] SUB_DIV32_LAST = 5'h1f;

  // Free-run wrap value and one-shot end count
  localparam logic [15:0] FREE_RUN_WRAP = 16'hffff;
  localparam logic [15:0] OS_LAST_COUNT = 16'h0001;

  // Clock source select
  localparam logic [1:0] CLK_UNDIV  = 2'h0;
  localparam logic [1:0] CLK_DIV8   = 2'h1;
  localparam logic [1:0] CLK_DIV32  = 2'h2;
  localparam logic [1:0] CLK_SUB32  = 2'h3;

  // Effective edge select
  localparam logic [1:0] EDGE_FALL  = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;

  // Event source select
  localparam logic [1:0] EVT_PIN    = 2'h0;
  localparam logic [1:0] EVT_TMR_B2 = 2'h1;
  localparam logic [1:0] EVT_TMR_A1 = 2'h2;
  localparam logic [1:0] EVT_TMR_X  = 2'h3;

  // One-shot trigger select
  localparam logic [1:0] TRIG_SW    = 2'h0;
  localparam logic [1:0] TRIG_PIN   = 2'h1;
  localparam logic [1:0] TRIG_OVF   = 2'h2;

  typedef enum logic [1:0] {
    MODE_TIMER    = 2'h0,
    MODE_EVENT    = 2'h1,
    MODE_ONESHOT  = 2'h2,
    MODE_RESERVED = 2'h3
  } timer_mode_t;

  typedef enum logic [1:0] {
    OS_IDLE   = 2'b01,
    OS_ACTIVE = 2'b10
  } os_state_t;

  typedef struct packed {
    logic [1:0]  trigSel;
    logic [1:0]  evtSel;
    logic [1:0]  edgeSel;
    logic        freeRun;
    logic        gateLevel;
    logic        gateEn;
    logic        pulseOut;
    logic [1:0]  rsvd;
    logic [1:0]  clkSel;
    timer_mode_t mode;
  } mode_reg_t;

endpackage : mtx_pkg

//--- multimode_timer_x_channel.sv
// One 16-bit down-counting timer channel: timer, event counter and one-shot.
// Assumes a classic Wishbone master on mclk and pin inputs synchronous to mclk.
//
// Notes on behaviour
// R1 - Timer mode counts undivided, /8, /32 clock or sub-clock /32.
// R2 - Timer and event modes count down and reload on underflow.
// R3 - Stored value n gives one underflow per n+1 source events.
// R4 - Timer and event modes count only while the start flag is 1.
// R5 - Timer and event modes raise the interrupt request on underflow.
// R6 - Reading the count register returns the live counter.
// R7 - Writing the count while stopped loads reload and counter together.
// R8 - Writing while counting updates reload only; counter takes it next reload.
// R9 - With gate selected, the pin level enables or suspends timer counting.
// R10 - With pulse output selected, the pin level inverts at each underflow.
// R11 - In timer mode the pin is port, gate input or pulse output.
// R12 - Event mode counts chosen pin edges or another timer's overflow.
// R13 - Free-run event counting wraps on underflow without reloading.
// R14 - In event mode the pin is port, count input or pulse output.
// R15 - One-shot countdown from n on the internal source lasts n periods.
// R16 - One-shot reaching zero loads the reload value, then halts.
// R17 - A trigger during a one-shot countdown reloads and restarts it.
// R18 - One-shot starts on pin trigger, timer overflow or software start flag.
// R19 - One-shot stops after the zero reload or when the start flag clears.
// R20 - One-shot raises the interrupt request when the count reaches zero.
// R21 - One-shot count reads are undefined; this block returns the counter.
// R22 - Mode register bits 0 and 1 choose the operating mode.
// R23 - Each instance keeps its own counter, reload, flags and pin logic.
`timescale 1ns/1ps

module multimode_timer_x_channel
  import mtx_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        subclockTick,
  input  wire logic        secondBTimerOverflow,
  input  wire logic        firstATimerOverflow,
  input  wire logic        neighbourXTimerOverflow,
  input  wire logic        ioPinIn,
  output logic             ioPinOut,
  output logic             ioPinOe_n,
  output logic             irqReq
);

  function automatic logic [15:0] mergeHalf(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
    mergeHalf = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : mergeHalf

  // Prescaler state
  logic [4:0]  preQ;
  logic [4:0]  preD;
  logic [4:0]  subQ;
  logic [4:0]  subD;

  // Bus and register state
  logic        ackQ;
  logic        ackD;
  logic [31:0] datQ;
  logic [31:0] datD;
  mode_reg_t   modeQ;
  mode_reg_t   modeD;
  logic        startQ;
  logic        startD;

  // Core state
  logic [15:0] cntQ;
  logic [15:0] cntD;
  logic [15:0] reloadQ;
  logic [15:0] reloadD;
  os_state_t   osQ;
  os_state_t   osD;
  logic        pinPrevQ;
  logic        pinOutQ;
  logic        pinOutD;
  logic        irqQ;
  logic        uflowStickyQ;
  logic        uflowStickyD;

  // Decoded terms
  logic        wbReq;
  logic        wrEn;
  logic        rdEn;
  logic        cntWr;
  logic [15:0] cntWrVal;
  logic        osSwStart;
  logic        stickyClr;
  logic        div8Tick;
  logic        div32Tick;
  logic        subTick;
  logic        internalTick;
  logic        pinRise;
  logic        pinFall;
  logic        pinEdge;
  logic        ovfSel;
  logic        eventTick;
  logic        gateOk;
  logic        countTick;
  logic        trigger;
  logic        running;
  logic        uflow;

  // Prescaler: one-cycle enables at the selected rate
  always_comb begin
    preD      = preQ + 5'h01;
    subD      = subclockTick ? subQ + 5'h01 : subQ;
    div8Tick  = (preQ[2:0] == PRE_DIV8_LAST);
    div32Tick = (preQ == PRE_DIV32_LAST);
    subTick   = subclockTick & (subQ == SUB_DIV32_LAST);
    case (modeQ.clkSel)                                      // see R1
      CLK_UNDIV: internalTick = 1'b1;
      CLK_DIV8:  internalTick = div8Tick;
      CLK_DIV32: internalTick = div32Tick;
      CLK_SUB32: internalTick = subTick;
      default:   internalTick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      preQ <= 5'h00;
      subQ <= 5'h00;
    end else begin
      preQ <= preD;
      subQ <= subD;
    end
  end

  // Bus decode and register writes
  always_comb begin
    wbReq     = cyc_i & stb_i & ~ackQ;
    // Writes land at the edge where the master sees ack
    wrEn      = cyc_i & stb_i & ackQ & we_i;
    rdEn      = wbReq & ~we_i;
    ackD      = wbReq;
    cntWr     = wrEn & (adr_i == ADDR_COUNT) & (sel_i[1] | sel_i[0]);
    cntWrVal  = mergeHalf(reloadQ, dat_i, sel_i);
    osSwStart = wrEn & (adr_i == ADDR_START) & sel_i[0] & dat_i[ONESHOT_BIT];
    stickyClr = wrEn & (adr_i == ADDR_STATUS) & sel_i[0] & dat_i[STAT_UFLOW];
    modeD     = modeQ;
    startD    = startQ;
    if (wrEn && adr_i == ADDR_MODE) begin
      modeD = mode_reg_t'(mergeHalf(modeQ, dat_i, sel_i));   // see R22
    end
    if (wrEn && adr_i == ADDR_START && sel_i[0]) begin
      startD = dat_i[START_BIT];                             // see R4
    end
    datD = datQ;
    if (rdEn) begin
      case (adr_i)
        ADDR_MODE:   datD = {16'h0000, modeQ};
        ADDR_START:  datD = {31'h0, startQ};
        ADDR_COUNT:  datD = {16'h0000, cntQ};                // see R6 R21
        ADDR_RELOAD: datD = {16'h0000, reloadQ};
        ADDR_STATUS: datD = {29'h0, uflowStickyQ, pinOutQ,
                             osQ == OS_ACTIVE};
        default:     datD = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ackQ   <= 1'b0;
      datQ   <= 32'h00000000;
      modeQ  <= mode_reg_t'(MODE_RST);
      startQ <= 1'b0;
    end else begin
      ackQ   <= ackD;
      datQ   <= datD;
      modeQ  <= modeD;
      startQ <= startD;
    end
  end

  assign ack_o = ackQ;
  assign dat_o = datQ;

  // Count sources, gate and triggers
  always_comb begin
    pinRise = ioPinIn & ~pinPrevQ;
    pinFall = ~ioPinIn & pinPrevQ;
    case (modeQ.edgeSel)                                     // see R12
      EDGE_FALL: pinEdge = pinFall;
      EDGE_RISE: pinEdge = pinRise;
      default:   pinEdge = pinRise | pinFall;
    endcase
    case (modeQ.evtSel)
      EVT_TMR_B2: ovfSel = secondBTimerOverflow;
      EVT_TMR_A1: ovfSel = firstATimerOverflow;
      EVT_TMR_X:  ovfSel = neighbourXTimerOverflow;
      default:    ovfSel = 1'b0;
    endcase
    eventTick = (modeQ.evtSel == EVT_PIN) ? pinEdge : ovfSel; // see R12 R14
    gateOk    = ~modeQ.gateEn | (ioPinIn == modeQ.gateLevel); // see R9 R11
    running   = (modeQ.mode == MODE_ONESHOT) ? (osQ == OS_ACTIVE) : startQ;
    case (modeQ.mode)
      MODE_TIMER:   countTick = startQ & internalTick & gateOk;     // see R4 R9
      MODE_EVENT:   countTick = startQ & eventTick;                 // see R4
      MODE_ONESHOT: countTick = (osQ == OS_ACTIVE) & internalTick;  // see R15
      default:      countTick = 1'b0;
    endcase
    case (modeQ.trigSel)                                     // see R18
      TRIG_PIN: trigger = pinEdge;
      TRIG_OVF: trigger = ovfSel;
      TRIG_SW:  trigger = 1'b0;
      default:  trigger = pinEdge | ovfSel;
    endcase
    trigger = (modeQ.mode == MODE_ONESHOT) & startQ & (trigger | osSwStart);
  end

  // Counter, reload and one-shot sequencing
  always_comb begin
    reloadD = cntWr ? cntWrVal : reloadQ;                    // see R8
    cntD    = cntQ;
    osD     = osQ;
    uflow   = 1'b0;
    if (cntWr && !running) begin
      cntD = cntWrVal;                                       // see R7
    end
    if (modeQ.mode == MODE_ONESHOT) begin
      case (osQ)
        OS_IDLE: begin
          if (trigger) begin
            cntD = reloadD;                                  // see R18
            osD  = OS_ACTIVE;
          end
        end
        OS_ACTIVE: begin
          if (!startQ) begin
            osD = OS_IDLE;                                   // see R19
          end else if (trigger) begin
            cntD = reloadD;                                  // see R17
          end else if (countTick) begin
            if (cntQ <= OS_LAST_COUNT) begin
              uflow = 1'b1;                                  // see R20
              cntD  = reloadD;                               // see R16
              osD   = OS_IDLE;                               // see R19
            end else begin
              cntD = cntQ - 16'h0001;                        // see R15
            end
          end
        end
        default: osD = OS_IDLE;
      endcase
    end else begin
      osD = OS_IDLE;
      if (countTick) begin
        if (cntQ == 16'h0000) begin
          uflow = 1'b1;                                      // see R3 R5
          if (modeQ.mode == MODE_EVENT && modeQ.freeRun) begin
            cntD = FREE_RUN_WRAP;                            // see R13
          end else begin
            cntD = reloadD;                                  // see R2 R8
          end
        end else begin
          cntD = cntQ - 16'h0001;                            // see R2
        end
      end
    end
    pinOutD      = pinOutQ ^ (uflow & modeQ.pulseOut);       // see R10
    uflowStickyD = uflow | (uflowStickyQ & ~stickyClr);
  end

  // Per-instance state only; no sharing across channels (see R23)
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cntQ         <= COUNT_RST;
      reloadQ      <= RELOAD_RST;
      osQ          <= OS_IDLE;
      pinPrevQ     <= 1'b0;
      pinOutQ      <= 1'b0;
      irqQ         <= 1'b0;
      uflowStickyQ <= 1'b0;
    end else begin
      cntQ         <= cntD;
      reloadQ      <= reloadD;
      osQ          <= osD;
      pinPrevQ     <= ioPinIn;
      pinOutQ      <= pinOutD;
      irqQ         <= uflow;                                 // see R5 R20
      uflowStickyQ <= uflowStickyD;
    end
  end

  assign irqReq    = irqQ;
  assign ioPinOut  = pinOutQ;
  // Pin driven only as pulse output; otherwise released to port or input
  assign ioPinOe_n = ~(modeQ.pulseOut & (modeQ.mode != MODE_RESERVED)); // see R11 R14

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic notOneshot;
  assign notOneshot = (modeQ.mode == MODE_TIMER) | (modeQ.mode == MODE_EVENT);

  underflow_reload_a: assert property ( // see R2
    (notOneshot && countTick && cntQ == 16'h0000 && !modeQ.freeRun && !cntWr)
      |=> (cntQ == $past(reloadQ)))
    else $error("counter did not reload on underflow");

  decrement_step_a: assert property ( // see R3
    (notOneshot && countTick && cntQ != 16'h0000 && !cntWr)
      |=> (cntQ == $past(cntQ) - 16'h0001))
    else $error("counter did not step down by one");

  stopped_hold_a: assert property ( // see R4
    (notOneshot && !startQ && !cntWr) |=> $stable(cntQ))
    else $error("counter moved while start flag clear");

  irq_underflow_a: assert property ( // see R5
    (notOneshot && countTick && cntQ == 16'h0000) |=> irqReq ##1 (irqReq == $past(uflow)))
    else $error("underflow did not raise one request pulse");

  read_count_a: assert property ( // see R6
    (rdEn && adr_i == ADDR_COUNT) |=> (ack_o && dat_o[15:0] == $past(cntQ)))
    else $error("count read did not return the live counter");

  write_stopped_a: assert property ( // see R7
    (cntWr && !running) |=> (cntQ == reloadQ && reloadQ == $past(cntWrVal)))
    else $error("stopped write did not load counter and reload");

  write_running_a: assert property ( // see R8
    (cntWr && running && !countTick && !trigger)
      |=> (reloadQ == $past(cntWrVal) && $stable(cntQ)))
    else $error("running write disturbed the counter");

  gate_hold_a: assert property ( // see R9
    (modeQ.mode == MODE_TIMER && modeQ.gateEn && ioPinIn != modeQ.gateLevel && !cntWr)
      |=> $stable(cntQ))
    else $error("counter moved while gate closed");

  pin_toggle_a: assert property ( // see R10
    (uflow && modeQ.pulseOut) |=> (ioPinOut != $past(ioPinOut)))
    else $error("pulse output did not invert on underflow");

  free_wrap_a: assert property ( // see R13
    (modeQ.mode == MODE_EVENT && modeQ.freeRun && countTick && cntQ == 16'h0000)
      |=> (cntQ == FREE_RUN_WRAP))
    else $error("free-run counter did not wrap");

  oneshot_halt_a: assert property ( // see R16
    (modeQ.mode == MODE_ONESHOT && osQ == OS_ACTIVE && startQ && !trigger
      && countTick && cntQ <= OS_LAST_COUNT)
      |=> (osQ == OS_IDLE && cntQ == $past(reloadD) && irqReq))
    else $error("one-shot did not reload and halt at zero");

  retrigger_load_a: assert property ( // see R17
    (modeQ.mode == MODE_ONESHOT && trigger) |=> (osQ == OS_ACTIVE && cntQ == $past(reloadD)))
    else $error("trigger did not restart the one-shot");

  oneshot_stop_a: assert property ( // see R19
    (modeQ.mode == MODE_ONESHOT && !startQ) |=> (osQ == OS_IDLE))
    else $error("one-shot kept running with start flag clear");

  timer_underflow_c: cover property (
    modeQ.mode == MODE_TIMER && uflow);
  event_wrap_c: cover property (
    modeQ.mode == MODE_EVENT && modeQ.freeRun && uflow);
  oneshot_retrigger_c: cover property (
    modeQ.mode == MODE_ONESHOT && osQ == OS_ACTIVE && trigger);
  oneshot_end_c: cover property (
    modeQ.mode == MODE_ONESHOT && uflow);

endmodule : multimode_timer_x_channel

//--- pin_pulse_source.sv
// External pulse source standing on the timer pin.
// Assumes mclk; holds the idle level while disabled.
`timescale 1ns/1ps
module pin_pulse_source (
  input  wire logic       mclk,
  input  wire logic       en,
  input  wire logic       idleLvl,
  input  wire logic [7:0] halfPer,
  output logic            lvl
);
  logic [7:0] cnt_q;
  always @(posedge mclk) begin
    if (!en) begin
      lvl <= idleLvl;
      cnt_q <= '0;
    end else if (cnt_q == halfPer - 8'h01) begin
      lvl <= ~lvl;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : pin_pulse_source

//--- tb_multimode_timer_x_channel.sv
// Self-checking bench for the timer channel.
// Assumes the pin source model and a 125 MHz mclk.
`timescale 1ns/1ps
module tb_multimode_timer_x_channel;
  import mtx_pkg::*;
  logic        mclk, nrst, cyc, stb, we, ack, subTick, ovfB, ovfA, ovfX;
  logic        pinIn, pinOut, pinOeN, irq, srcEn, srcIdle, srcLvl, pinPrev, pinLast;
  logic [7:0]  adr;
  logic [31:0] dat, datO;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  int          errTotal, testsRun, irqCount, cycNow, irqPrev, irqLast, seed;
  int          ovfCnt[3];
  int          dv[4] = '{1, 8, 32, 64};

  multimode_timer_x_channel multimode_timer_x_channel_inst (
    .mclk(mclk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(dat), .sel_i(4'hf), .dat_o(datO), .ack_o(ack), .subclockTick(subTick),
    .secondBTimerOverflow(ovfB), .firstATimerOverflow(ovfA),
    .neighbourXTimerOverflow(ovfX), .ioPinIn(pinIn), .ioPinOut(pinOut),
    .ioPinOe_n(pinOeN), .irqReq(irq));
  pin_pulse_source pin_pulse_source_inst (
    .mclk(mclk), .en(srcEn), .idleLvl(srcIdle), .halfPer(8'h03), .lvl(srcLvl));
  assign pinIn = (pinOeN === 1'b0) ? pinOut : srcLvl;

  always #4 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic testDone();
    $display("checks=%0d errors=%0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : testDone

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    expQ.push_back(e);
    mskQ.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd

  function automatic mode_reg_t mk(input logic [1:0] md, cs, ed, ev, tr, input logic [3:0] fl);
    return mode_reg_t'({tr, ev, ed, fl, 2'b00, cs, md});
  endfunction : mk

  task automatic setup(input mode_reg_t m, input logic [15:0] n);
    bus(1'b1, ADDR_START, 32'h0);
    bus(1'b1, ADDR_MODE, {16'h0, m});
    bus(1'b1, ADDR_COUNT, {16'h0, n});
    rd(ADDR_RELOAD, {16'h0, n});
    if (m.mode[1] == 1'b0) rd(ADDR_COUNT, {16'h0, n});
    bus(1'b1, ADDR_START, 32'h1);
  endtask : setup

  task automatic gap(input int exp, input logic pulse);
    int c0;
    c0 = irqCount;
    wait (irqCount >= c0 + 3);
    chk(irqLast - irqPrev, exp);
    if (pulse) chk(pinLast ^ pinPrev, 32'h1);
  endtask : gap

  task automatic quiet(input int n, input int add);
    int c0;
    repeat (2) @(posedge mclk);
    c0 = irqCount;
    repeat (n) @(posedge mclk);
    chk(irqCount - c0, add);
  endtask : quiet

  task automatic shot(input logic [15:0] n, output int d);
    int c0;
    setup(mk(MODE_ONESHOT, CLK_UNDIV, 2'h0, 2'h0, TRIG_SW, 4'h0), n);
    c0 = irqCount;
    bus(1'b1, ADDR_START, 32'h3);
    d = cycNow;
    wait (irqCount > c0);
    d = irqLast - d;
  endtask : shot

  // Monitor: read data against the oldest note, interrupt timing
  always @(posedge mclk) begin : mon
    logic [31:0] m, e;
    cycNow = cycNow + 1;
    if (ack === 1'b1 && cyc && !we && expQ.size() > 0) begin
      m = mskQ.pop_front();
      e = expQ.pop_front();
      chk(datO & m, e);
    end
    if (irq === 1'b1) begin
      irqPrev = irqLast;
      irqLast = cycNow;
      pinPrev = pinLast;
      pinLast = pinOut;
      irqCount++;
    end
  end

  // Overflow pulses of periods 5, 7, 9 and a sub-clock tick every other cycle
  always @(posedge mclk) begin
    for (int i = 0; i < 3; i++) ovfCnt[i] <= (ovfCnt[i] == 4 + 2 * i) ? 0 : ovfCnt[i] + 1;
    ovfB <= (ovfCnt[0] == 4);
    ovfA <= (ovfCnt[1] == 6);
    ovfX <= (ovfCnt[2] == 8);
    subTick <= ~subTick;
  end

  initial begin
    #200000;
    errTotal++;
    testDone();
  end

  initial begin
    int n, d1, d2, t, c0;
    mclk = 0; nrst = 0; cyc = 0; stb = 0; we = 0; adr = '0; dat = '0;
    subTick = 0; ovfB = 0; ovfA = 0; ovfX = 0; srcEn = 0; srcIdle = 0;
    errTotal = 0; testsRun = 0; irqCount = 0; cycNow = 0; irqPrev = 0; irqLast = 0;
    pinPrev = 0; pinLast = 0; seed = 13572; ovfCnt = '{0, 0, 0};
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rd(ADDR_MODE, {16'h0, MODE_RST});
    rd(ADDR_COUNT, {16'h0, COUNT_RST});
    rd(ADDR_RELOAD, {16'h0, RELOAD_RST});
    rd(8'h14, 32'h0);
    chk(pinOeN, 1'b1);
    for (int k = 0; k < 4; k++) begin
      n = 1 + ($random(seed) & 3);
      setup(mk(MODE_TIMER, k[1:0], 2'h0, 2'h0, 2'h0, 4'h1), n[15:0]);
      chk(pinOeN, 1'b0);
      gap((n + 1) * dv[k], 1'b1);
    end
    setup(mk(MODE_TIMER, CLK_UNDIV, 2'h0, 2'h0, 2'h0, 4'h0), 16'h3);
    bus(1'b1, ADDR_COUNT, 32'h7);
    rd(ADDR_RELOAD, 32'h7);
    gap(8, 1'b0);
    bus(1'b1, ADDR_START, 32'h0);
    quiet(50, 0);
    setup(mk(MODE_RESERVED, CLK_UNDIV, 2'h0, 2'h0, 2'h0, 4'h0), 16'h2);
    quiet(50, 0);
    setup(mk(MODE_TIMER, CLK_UNDIV, 2'h0, 2'h0, 2'h0, 4'h6), 16'h2);
    quiet(40, 0);
    srcIdle <= 1'b1;
    gap(3, 1'b0);
    srcIdle <= 1'b0;
    srcEn <= 1'b1;
    for (int e = 0; e < 3; e++) begin
      setup(mk(MODE_EVENT, CLK_UNDIV, e[1:0], EVT_PIN, 2'h0, 4'h0), 16'h2);
      gap(e == 2 ? 9 : 18, 1'b0);
    end
    srcEn <= 1'b0;
    for (int e = 1; e < 4; e++) begin
      setup(mk(MODE_EVENT, CLK_UNDIV, 2'h0, e[1:0], 2'h0, 4'h0), 16'h2);
      gap(3 * (3 + 2 * e), 1'b0);
    end
    setup(mk(MODE_EVENT, CLK_UNDIV, 2'h0, EVT_TMR_X, 2'h0, 4'h8), 16'h2);
    c0 = irqCount;
    wait (irqCount > c0);
    bus(1'b1, ADDR_START, 32'h0);
    rd(ADDR_COUNT, {16'h0, FREE_RUN_WRAP});
    shot(16'h3, d1);
    shot(16'h6, d2);
    chk(d2 - d1, 3);
    quiet(40, 0);
    rd(ADDR_STATUS, 32'h4, 32'h5);
    bus(1'b1, ADDR_STATUS, 32'h4);
    rd(ADDR_STATUS, 32'h0, 32'h4);
    c0 = irqCount;
    bus(1'b1, ADDR_START, 32'h3);
    repeat (2) @(posedge mclk);
    bus(1'b1, ADDR_START, 32'h3);
    t = cycNow;
    wait (irqCount > c0);
    chk(irqLast - t, d2);
    bus(1'b1, ADDR_START, 32'h3);
    bus(1'b1, ADDR_START, 32'h0);
    quiet(30, 0);
    setup(mk(MODE_ONESHOT, CLK_UNDIV, EDGE_RISE, 2'h0, TRIG_PIN, 4'h0), 16'h6);
    srcIdle <= 1'b1;
    quiet(30, 1);
    srcIdle <= 1'b0;
    setup(mk(MODE_ONESHOT, CLK_UNDIV, 2'h0, EVT_TMR_X, TRIG_OVF, 4'h0), 16'h3);
    gap(9, 1'b0);
    testDone();
  end
endmodule : tb_multimode_timer_x_channel
